// [verif/pcm_voice_codec_serial_port_tb.sv]
// Bench joining the highway master and the codec device over one link.
// Assumes the design package and link interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pcm_voice_codec_serial_port_tb;
  import pvc_pkg::*;
  localparam int SYNC_IDLE = 5400;
  logic       clock, rst_n, send_valid, tx_valid, send_ready, tx_ready;
  logic [7:0] send_code, tx_sample, recv_code, rx_sample, rx_code;
  logic       recv_valid, rx_valid, power_save, power_down;
  logic       link_enable, sync_enable, power_down_req, law_a, law_drive;
  logic       got_h, got_d;
  int         cnt_h, cnt_d, base_h, base_d;
  logic [7:0] h_code, d_code, d_samp, exp_h, exp_c, exp_s, c;
  logic [7:0] corner [4] = '{8'hFF, 8'h80, 8'h00, 8'h7F};
  logic [7:0] mu_tab [4] = '{8'h80, 8'hFF, 8'h7F, 8'h00};
  logic [7:0] a_tab [4]  = '{8'hAA, 8'hD5, 8'h55, 8'h2A};
  int         mismatches, checked, f, n;
  logic       law;

  // A word has arrived on an end since the last mark was taken
  assign got_h = (cnt_h != base_h);
  assign got_d = (cnt_d != base_d);

  pvc_link_if link ();
  pvc_host pvc_host_inst (.CLOCK(clock), .RST_N(rst_n), .LINK(link),
    .SEND_CODE(send_code), .SEND_VALID(send_valid), .SEND_READY(send_ready),
    .RECV_CODE(recv_code), .RECV_VALID(recv_valid),
    .LINK_ENABLE(link_enable), .SYNC_ENABLE(sync_enable),
    .POWER_DOWN_REQ(power_down_req), .LAW_A(law_a), .LAW_DRIVE(law_drive));
  pvc_device #(.SYNC_IDLE_CYCLES(SYNC_IDLE)) pvc_device_inst (
    .CLOCK(clock), .RST_N(rst_n), .LINK(link), .TX_SAMPLE(tx_sample),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_SAMPLE(rx_sample),
    .RX_CODE(rx_code), .RX_VALID(rx_valid), .POWER_SAVE(power_save),
    .POWER_DOWN(power_down));
  pvc_link_sva pvc_link_sva_inst (.bit_clock(link.bit_clock),
    .RST_N(rst_n), .transmit_frame_sync(link.transmit_frame_sync),
    .receive_frame_sync(link.receive_frame_sync),
    .power_down_control(link.power_down_control), .tdo_oe(link.tdo_oe),
    .transmit_data_output(link.transmit_data_output),
    .law_oe(link.law_oe), .law_select_input(link.law_select_input));

  // 40 MHz system clock
  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  // Latch each received word on either end
  always @(posedge clock) begin
    if (recv_valid === 1'b1) begin
      cnt_h  <= cnt_h + 1;
      h_code <= recv_code;
    end
    if (rx_valid === 1'b1) begin
      cnt_d  <= cnt_d + 1;
      d_code <= rx_code;
      d_samp <= rx_sample;
    end
  end

  // Mask applied by the line code of each law
  function automatic logic [7:0] law_mask(input logic a);
    return a ? 8'h55 : 8'h7F;
  endfunction

  task automatic check(input logic [7:0] seen, exp, input string what);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Offer a word to each end at once; each drops valid once taken
  task automatic push(input logic [7:0] code, samp);
    logic rh, rd;
    @(posedge clock);
    #1;
    send_code  = code;
    tx_sample  = samp;
    send_valid = 1'b1;
    tx_valid   = 1'b1;
    for (n = 0; n < 8000 && (send_valid || tx_valid); n++) begin
      rh = send_ready;
      rd = tx_ready;
      @(posedge clock);
      #1;
      if (rh === 1'b1) send_valid = 1'b0;
      if (rd === 1'b1) tx_valid = 1'b0;
    end
    check({7'h00, send_valid | tx_valid}, 8'h00, "word not taken");
  endtask

  // Wait for a word on both ends; bounded by one frame and a margin
  task automatic wait_words();
    for (n = 0; n < 7000 && !(got_h && got_d); n++) @(posedge clock);
    #1;
    check({7'h00, got_h & got_d}, 8'h01, "frame words missing");
  endtask

  task automatic wait_awake();
    for (n = 0; n < 8000 && power_save !== 1'b0; n++) @(posedge clock);
    #1;
    check({7'h00, power_save}, 8'h00, "power save stuck");
  endtask

  // Hang guard sized well past the expected run
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    conclude();
  end

  initial begin
    {send_valid, tx_valid, power_down_req, law_a, law_drive} = 5'h00;
    {send_code, tx_sample} = 16'h0000;
    {link_enable, sync_enable} = 2'b11;
    {mismatches, checked} = '0;
    rst_n = 1'b0;
    void'($urandom(61825));
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    // Idle words first, then mu-law, A-law and an open law pin
    {exp_h, exp_c, exp_s} = {8'hFF, 8'hFF, 8'h80};
    for (f = 0; f <= 10; f++) begin
      wait_words();
      check(h_code, exp_h, "device word");
      check(d_code, exp_c, "received code");
      check(d_samp, exp_s, "received sample");
      {base_h, base_d} = {cnt_h, cnt_d};
      if (f < 10) begin
        law       = (f >= 4 && f < 8);
        law_a     = (f >= 4);
        law_drive = (f < 8);
        c         = (f == 0) ? 8'h00 : 8'($urandom);
        exp_h     = law ? a_tab[f % 4] : mu_tab[f % 4];
        exp_c     = c;
        exp_s     = c ^ law_mask(law);
        push(c, corner[f % 4]);
      end
    end
    // Transmit sync held low until power save
    sync_enable = 1'b0;
    repeat (SYNC_IDLE + 600) @(posedge clock);
    #1;
    check({7'h00, power_save}, 8'h01, "sync idle save");
    sync_enable = 1'b1;
    wait_awake();
    // Bit clock stopped after a slot until power save
    {base_h, base_d} = {cnt_h, cnt_d};
    wait_words();
    repeat (400) @(posedge clock);
    #1;
    link_enable = 1'b0;
    repeat (1500) @(posedge clock);
    #1;
    check({7'h00, power_save}, 8'h01, "clock idle save");
    link_enable = 1'b1;
    wait_awake();
    // Power down: no received word, released line; an awake device would
    // send the A-law idle code in the slot, so a high line proves release
    power_down_req = 1'b1;
    {law_a, law_drive} = 2'b11;
    repeat (8) @(posedge clock);
    #1;
    check({7'h00, power_down}, 8'h01, "power down flag");
    {base_h, base_d} = {cnt_h, cnt_d};
    repeat (7000) @(posedge clock);
    #1;
    check({7'h00, got_d}, 8'h00, "word in power down");
    check({7'h00, got_h}, 8'h01, "line not sampled");
    check(h_code, 8'hFF, "line in power down");
    power_down_req = 1'b0;
    conclude();
  end
endmodule
`default_nettype wire

// [verif/pvc_link_sva.sv]
// Checker for the codec link: watches the shared wires of both ends.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module pvc_link_sva (
  // Link clock and reset
  input wire logic bit_clock,
  input wire logic RST_N,
  // Syncs and power pin from the master
  input wire logic transmit_frame_sync,
  input wire logic receive_frame_sync,
  input wire logic power_down_control,
  // Open-drain data line
  input wire logic tdo_oe,
  input wire logic transmit_data_output,
  // Law pin
  input wire logic law_oe,
  input wire logic law_select_input
);
  logic [4:0] since_sync;
  logic       sync_prev;

  default clocking link_cb @(posedge bit_clock);
  endclocking
  default disable iff (!RST_N);

  // Bit clocks since the last transmit sync rise; saturates so a long
  // silence keeps the slot window closed
  always_ff @(posedge bit_clock or negedge RST_N) begin
    if (!RST_N) begin
      since_sync <= 5'h1F;
      sync_prev  <= 1'b0;
    end else begin
      sync_prev <= transmit_frame_sync;
      if (transmit_frame_sync && !sync_prev) begin
        since_sync <= 5'h00;
      end else if (since_sync != 5'h1F) begin
        since_sync <= since_sync + 5'h01;
      end
    end
  end

  // Slot steps: take edge, eight bits, then a quiet line
  sequence s_take;
    $rose(transmit_frame_sync);
  endsequence
  sequence s_released;
    !tdo_oe ##9 (!tdo_oe) [*8];
  endsequence

  property p_sync_width;
    $rose(transmit_frame_sync) |=> !transmit_frame_sync;
  endproperty
  a_sync_width: assert property (p_sync_width)
    else $error("transmit sync wider than one bit");
  property p_rx_spacing;
    $rose(receive_frame_sync) |=> (!receive_frame_sync) [*8];
  endproperty
  a_rx_spacing: assert property (p_rx_spacing)
    else $error("receive syncs closer than nine bits");
  property p_slot_release;
    s_take |-> s_released;
  endproperty
  a_slot_release: assert property (p_slot_release)
    else $error("data line driven outside the word slot");
  property p_slot_window;
    since_sync >= 5'd8 |-> !tdo_oe;
  endproperty
  a_slot_window: assert property (p_slot_window)
    else $error("slot not started by a transmit sync");
  property p_pdown_quiet;
    (!power_down_control) [*5] |-> !tdo_oe;
  endproperty
  a_pdown_quiet: assert property (p_pdown_quiet)
    else $error("data line driven in power down");
  property p_line_low;
    tdo_oe |-> !transmit_data_output;
  endproperty
  a_line_low: assert property (p_line_low)
    else $error("driven data line not low");
  property p_pullup;
    !tdo_oe |-> transmit_data_output;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("released data line not high");
  property p_law_default;
    !law_oe |-> !law_select_input;
  endproperty
  a_law_default: assert property (p_law_default)
    else $error("open law pin not low");
endmodule
`default_nettype wire

// [verilog/pvc_device.sv]
// Digital side of a single-channel voice codec serial port.
// Assumes the host supplies bit clock and syncs; user side runs on CLOCK.
// Overview of operation
// - Shift input on falling edges, hold after eight
// - First digit is bit at receive sync rise
// - Data rate equals bit clock, listed rates
// - Stuck bit clock or transmit sync: power save
// - Receive sync frames and times receive words
// - Master keeps syncs phase locked to clock
// - Sync rate 8 kHz, tolerances as given
// - Transmit timing derives from transmit sync
// - Transmit most significant digit first, rising edges
// - First digit may start at transmit sync rise
// - Output released outside slot and while asleep; a bit clock stopped mid-slot leaves pull_low held, so the line keeps the level of its last bit
// - External pull-up on open-drain output
// - Power-down input low powers both sections down
// - Law input low mu-law, high A-law
// - Law input pulled down, defaults mu-law
// - Mu-law code points as listed
// - A-law inverts even bits, listed codes
`timescale 1ns/1ps
`default_nettype none
module pvc_device #(
  parameter int SYNC_IDLE_CYCLES = `PVC_SYNC_IDLE_CYCLES
) (
  // System
  input  wire logic             CLOCK,
  input  wire logic             RST_N,
  // Link
  pvc_link_if.device            LINK,
  // Transmit samples, sign-magnitude
  input  wire logic [7:0]       TX_SAMPLE,
  input  wire logic             TX_VALID,
  output logic                  TX_READY,
  // Received words
  output logic [7:0]            RX_SAMPLE,
  output logic [7:0]            RX_CODE,
  output logic                  RX_VALID,
  // Status
  output logic                  POWER_SAVE,
  output logic                  POWER_DOWN
);
  import pvc_pkg::*;

  localparam logic [13:0] BCLK_LIMIT = 14'(`PVC_BCLK_IDLE_CYCLES);
  localparam logic [13:0] SYNC_LIMIT = 14'(SYNC_IDLE_CYCLES);

  pvc_sys_type s;
  pvc_sys_type next_s;
  pvc_rx_type  r;
  pvc_rx_type  next_r;
  pvc_tx_type  t;
  pvc_tx_type  next_t;
  logic        rx_start;
  logic        tx_start;
  logic        tx_take;
  logic [7:0]  tx_code;

  // User side: activity watch, power state and word crossings
  always_comb begin
    next_s = s;
    next_s.bclk_meta = {s.bclk_meta[0], LINK.bit_clock};
    next_s.bclk_prev = s.bclk_meta[1];
    next_s.sync_meta = {s.sync_meta[0], LINK.transmit_frame_sync};
    next_s.sync_prev = s.sync_meta[1];
    next_s.pwr_meta = {s.pwr_meta[0], LINK.power_down_control};
    next_s.law_meta = {s.law_meta[0], LINK.law_select_input};
    // A frozen clock or sync level stops its counter from clearing
    if (s.bclk_meta[1] != s.bclk_prev) begin
      next_s.bclk_idle = 14'h0000;
    end else if (s.bclk_idle != BCLK_LIMIT) begin
      next_s.bclk_idle = s.bclk_idle + 14'h0001;
    end
    if (s.sync_meta[1] && !s.sync_prev) begin
      next_s.sync_idle = 14'h0000;
    end else if (s.sync_idle != SYNC_LIMIT) begin
      next_s.sync_idle = s.sync_idle + 14'h0001;
    end
    next_s.save = (s.bclk_idle == BCLK_LIMIT) ||
                  (s.sync_idle == SYNC_LIMIT);
    next_s.pdown = ~s.pwr_meta[1];
    next_s.asleep = next_s.save | next_s.pdown;
    // Received word: hold register is stable for a whole frame
    next_s.rx_meta = {s.rx_meta[0], r.toggle};
    next_s.rx_valid = 1'b0;
    if (s.rx_meta[1] != s.rx_seen) begin
      next_s.rx_seen = s.rx_meta[1];
      next_s.rx_code = r.hold;
      next_s.rx_sample = pvc_code(r.hold, s.law_meta[1]);
      next_s.rx_valid = 1'b1;
    end
    // Transmit word waits until the link side returns the toggle
    next_s.ack_meta = {s.ack_meta[0], t.ack};
    if (TX_VALID && s.tx_ready) begin
      next_s.tx_word = TX_SAMPLE;
      next_s.tx_req = ~s.tx_req;
    end
    next_s.tx_ready = (s.ack_meta[1] == next_s.tx_req);
  end

  // Receive section, falling edges of the bit clock
  always_comb begin
    next_r = r;
    next_r.sleep_meta = {r.sleep_meta[0], s.asleep};
    next_r.sync_prev = LINK.receive_frame_sync;
    rx_start = LINK.receive_frame_sync && !r.sync_prev;
    if (r.sleep_meta[1]) begin
      // Partial word is dropped; capture waits for a fresh sync edge
      next_r.phase = PVC_WAIT;
      next_r.count = 3'h0;
    end else if (rx_start) begin
      next_r.shift = {r.shift[6:0], LINK.receive_data_input};
      next_r.count = 3'h1;
      next_r.phase = PVC_SHIFT;
    end else begin
      case (r.phase)
        PVC_WAIT: begin
          next_r.count = 3'h0;
        end
        PVC_SHIFT: begin
          next_r.shift = {r.shift[6:0], LINK.receive_data_input};
          next_r.count = r.count + 3'h1;
          if (r.count == 3'h7) begin
            next_r.hold = {r.shift[6:0], LINK.receive_data_input};
            next_r.toggle = ~r.toggle;
            next_r.phase = PVC_WAIT;
          end
        end
        default: begin
          next_r.phase = PVC_WAIT;
        end
      endcase
    end
  end

  // Transmit section, rising edges of the bit clock
  always_comb begin
    next_t = t;
    next_t.sleep_meta = {t.sleep_meta[0], s.asleep};
    next_t.law_meta = {t.law_meta[0], LINK.law_select_input};
    next_t.req_meta = {t.req_meta[0], s.tx_req};
    next_t.sync_prev = LINK.transmit_frame_sync;
    tx_start = LINK.transmit_frame_sync && !t.sync_prev;
    tx_take = (t.req_meta[1] != t.req_seen);
    // No fresh sample means the law's positive zero goes out
    tx_code = pvc_code(tx_take ? s.tx_word : `PVC_IDLE_SAMPLE,
                       t.law_meta[1]);
    if (t.sleep_meta[1]) begin
      next_t.phase = PVC_WAIT;
      next_t.pull_low = 1'b0;
      next_t.count = 3'h0;
    end else if (tx_start) begin
      // First digit leaves on the edge that finds the sync risen
      next_t.pull_low = ~tx_code[7];
      next_t.shift = {tx_code[6:0], 1'b1};
      next_t.count = 3'h1;
      next_t.phase = PVC_SHIFT;
      next_t.req_seen = t.req_meta[1];
      next_t.ack = t.req_meta[1];
    end else begin
      case (t.phase)
        PVC_WAIT: begin
          next_t.pull_low = 1'b0;
        end
        PVC_SHIFT: begin
          if (t.count == 3'h0) begin
            next_t.pull_low = 1'b0;
            next_t.phase = PVC_WAIT;
          end else begin
            next_t.pull_low = ~t.shift[7];
            next_t.shift = {t.shift[6:0], 1'b1};
            next_t.count = t.count + 3'h1;
          end
        end
        default: begin
          next_t.phase = PVC_WAIT;
          next_t.pull_low = 1'b0;
        end
      endcase
    end
  end

  // User-side register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Receive register; the reset release is not aligned to the link clock
  always_ff @(negedge LINK.bit_clock or negedge RST_N) begin
    if (!RST_N) begin
      r <= '0;
      r.phase <= PVC_WAIT;
    end else begin
      r <= next_r;
    end
  end

  // Transmit register
  always_ff @(posedge LINK.bit_clock or negedge RST_N) begin
    if (!RST_N) begin
      t <= '0;
      t.phase <= PVC_WAIT;
    end else begin
      t <= next_t;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign LINK.tdo_o = 1'b0;
  assign LINK.tdo_oe = t.pull_low;
  assign TX_READY = s.tx_ready;
  assign RX_SAMPLE = s.rx_sample;
  assign RX_CODE = s.rx_code;
  assign RX_VALID = s.rx_valid;
  assign POWER_SAVE = s.save;
  assign POWER_DOWN = s.pdown;
endmodule
`default_nettype wire

// [verilog/pvc_host.sv]
// Highway master for the voice codec: makes the bit clock and both syncs,
// sends receive words and collects transmit words.
// Assumes the link interface joins it to the device end.
`timescale 1ns/1ps
`default_nettype none
module pvc_host (
  // System
  input  wire logic             CLOCK,
  input  wire logic             RST_N,
  // Link
  pvc_link_if.host              LINK,
  // Words toward the device
  input  wire logic [7:0]       SEND_CODE,
  input  wire logic             SEND_VALID,
  output logic                  SEND_READY,
  // Words from the device
  output logic [7:0]            RECV_CODE,
  output logic                  RECV_VALID,
  // Pin controls
  input  wire logic             LINK_ENABLE,
  input  wire logic             SYNC_ENABLE,
  input  wire logic             POWER_DOWN_REQ,
  input  wire logic             LAW_A,
  input  wire logic             LAW_DRIVE
);
  import pvc_pkg::*;

  localparam logic [7:0] HALF     = 8'(`PVC_HALF_BIT_CYCLES);
  localparam logic [7:0] MID_HIGH = 8'(`PVC_HALF_BIT_CYCLES / 2);
  localparam logic [7:0] MID_LOW  = 8'(`PVC_HALF_BIT_CYCLES * 3 / 2);
  localparam logic [7:0] SAMPLE   = 8'(`PVC_HALF_BIT_CYCLES + 2);
  localparam logic [7:0] DIV_LAST = 8'(`PVC_HALF_BIT_CYCLES * 2 - 1);
  localparam logic [4:0] BIT_LAST = 5'(`PVC_FRAME_BITS - 1);
  localparam logic [4:0] WORD_END = 5'(`PVC_WORD_BITS);

  pvc_host_type h;
  pvc_host_type next_h;

  // Frame generator; outputs change mid-phase so no edge races the clock
  always_comb begin
    next_h = h;
    next_h.line_meta = {h.line_meta[0], LINK.transmit_data_output};
    next_h.recv_valid = 1'b0;
    next_h.pwr_o = ~POWER_DOWN_REQ;
    next_h.law_o = LAW_A;
    next_h.law_oe = LAW_DRIVE;
    if (SEND_VALID && h.send_ready) begin
      next_h.pend = SEND_CODE;
      next_h.pend_full = 1'b1;
    end
    if (!LINK_ENABLE) begin
      // Stopped clock is how the master parks the device in power save
      next_h.div = 8'h00;
      next_h.bit_no = 5'h00;
      next_h.bclk = 1'b0;
      next_h.rx_sync = 1'b0;
      next_h.tx_sync = 1'b0;
    end else begin
      if (h.div == DIV_LAST) begin
        next_h.div = 8'h00;
        next_h.bit_no = (h.bit_no == BIT_LAST) ? 5'h00 : h.bit_no + 5'h01;
      end else begin
        next_h.div = h.div + 8'h01;
      end
      // Data rate equals bit clock rate, 200 kHz; 25 bits make 8 kHz
      if (h.div == 8'h00) begin
        next_h.bclk = 1'b1;
        if (h.bit_no == 5'h00) begin
          // A word taken in this very cycle must survive to the next frame
          next_h.cur = h.pend_full ? h.pend : `PVC_IDLE_CODE;
          if (h.pend_full) begin
            next_h.pend_full = 1'b0;
          end
        end
      end
      if (h.div == HALF) begin
        next_h.bclk = 1'b0;
      end
      // Receive sync rises with the most significant digit
      if (h.div == MID_HIGH) begin
        next_h.rx_sync = (h.bit_no == 5'h00);
        next_h.rx_data = (h.bit_no < WORD_END) ? h.cur[7] : 1'b1;
        if (h.bit_no < WORD_END) begin
          next_h.cur = {h.cur[6:0], 1'b1};
        end
      end
      // Transmit sync rises a quarter bit before bit 0
      if (h.div == MID_LOW) begin
        next_h.tx_sync = SYNC_ENABLE && (h.bit_no == BIT_LAST);
      end
      // Sample the pulled-up line near the falling edge
      if (h.div == SAMPLE && h.bit_no < WORD_END) begin
        next_h.rshift = {h.rshift[6:0], h.line_meta[1]};
        if (h.bit_no == WORD_END - 5'h01) begin
          next_h.recv = {h.rshift[6:0], h.line_meta[1]};
          next_h.recv_valid = 1'b1;
        end
      end
    end
    next_h.send_ready = ~next_h.pend_full;
  end

  // State register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      h <= '0;
    end else begin
      h <= next_h;
    end
  end

  assign LINK.bit_clock = h.bclk;
  assign LINK.transmit_frame_sync = h.tx_sync;
  assign LINK.receive_frame_sync = h.rx_sync;
  assign LINK.receive_data_input = h.rx_data;
  assign LINK.power_down_control = h.pwr_o;
  assign LINK.law_o = h.law_o;
  assign LINK.law_oe = h.law_oe;
  assign SEND_READY = h.send_ready;
  assign RECV_CODE = h.recv;
  assign RECV_VALID = h.recv_valid;
endmodule
`default_nettype wire

// [verilog/pvc_link_if.sv]
// Serial PCM highway between a codec device and its highway master.
// Resolves the open-drain data line and the pulled-down law pin.
`timescale 1ns/1ps
`default_nettype none
interface pvc_link_if;
  logic bit_clock;
  logic transmit_frame_sync;
  logic receive_frame_sync;
  logic receive_data_input;
  logic power_down_control;
  logic tdo_o;
  logic tdo_oe;
  logic transmit_data_output;
  logic law_o;
  logic law_oe;
  logic law_select_input;

  // Line reads high unless the device pulls it low
  assign transmit_data_output = ~(tdo_oe & ~tdo_o);
  // Undriven law pin falls to mu-law
  assign law_select_input = law_oe & law_o;

  modport device (
    input  bit_clock, transmit_frame_sync, receive_frame_sync,
    input  receive_data_input, power_down_control, law_select_input,
    output tdo_o, tdo_oe
  );
  modport host (
    output bit_clock, transmit_frame_sync, receive_frame_sync,
    output receive_data_input, power_down_control, law_o, law_oe,
    input  transmit_data_output
  );
endinterface
`default_nettype wire

// [verilog/pvc_map.svh]
// Constants of the voice codec serial port: code masks, frame shape and
// timing counts.
// Assumes a 40 MHz system clock and a 200 kHz bit clock made by the host.
`ifndef PVC_MAP_SVH
`define PVC_MAP_SVH

// System clock
`define PVC_CLOCK_PERIOD_NS 25

// Power save detection: bit clock silent for two periods of 64 kHz
`define PVC_BCLK_IDLE_NS 31250
`define PVC_BCLK_IDLE_CYCLES (`PVC_BCLK_IDLE_NS / `PVC_CLOCK_PERIOD_NS)
// Power save detection: no transmit sync edge for two slowest frames
`define PVC_SYNC_IDLE_NS 250000
`define PVC_SYNC_IDLE_CYCLES (`PVC_SYNC_IDLE_NS / `PVC_CLOCK_PERIOD_NS)

// Host bit clock: 40 MHz / (2 * 100) = 200 kHz, 25 bits give 8 kHz
`define PVC_HALF_BIT_CYCLES 100
`define PVC_FRAME_BITS 25
`define PVC_WORD_BITS 8

// Code masks: mu-law inverts magnitude, A-law inverts even bits
`define PVC_MU_MASK 8'h7F
`define PVC_A_MASK 8'h55
// Sign-magnitude positive zero, sent when no sample is waiting
`define PVC_IDLE_SAMPLE 8'h80
// Wire code sent by the host when it has no word (mu-law positive zero)
`define PVC_IDLE_CODE 8'hFF

`endif

// [verilog/pvc_pkg.sv]
// Types and the code conversion shared by both ends of the codec link.
// Assumes pvc_map.svh is on the include path.
package pvc_pkg;
  `include "pvc_map.svh"

  // Word phase of either shifter
  typedef enum logic [1:0] {
    PVC_WAIT  = 2'b01,
    PVC_SHIFT = 2'b10
  } pvc_phase_type;

  // Receive shifter, falling edges of the bit clock
  typedef struct packed {
    pvc_phase_type phase;
    logic [2:0]    count;
    logic [7:0]    shift;
    logic [7:0]    hold;
    logic          toggle;
    logic          sync_prev;
    logic [1:0]    sleep_meta;
  } pvc_rx_type;

  // Transmit shifter, rising edges of the bit clock
  typedef struct packed {
    pvc_phase_type phase;
    logic [2:0]    count;
    logic [7:0]    shift;
    logic          pull_low;
    logic          sync_prev;
    logic [1:0]    req_meta;
    logic          req_seen;
    logic          ack;
    logic [1:0]    sleep_meta;
    logic [1:0]    law_meta;
  } pvc_tx_type;

  // Device user side on the system clock
  typedef struct packed {
    logic [1:0]  bclk_meta;
    logic        bclk_prev;
    logic [1:0]  sync_meta;
    logic        sync_prev;
    logic [13:0] bclk_idle;
    logic [13:0] sync_idle;
    logic        save;
    logic        pdown;
    logic        asleep;
    logic [1:0]  pwr_meta;
    logic [1:0]  law_meta;
    logic [1:0]  rx_meta;
    logic        rx_seen;
    logic [1:0]  ack_meta;
    logic        tx_req;
    logic        tx_ready;
    logic [7:0]  tx_word;
    logic [7:0]  rx_sample;
    logic [7:0]  rx_code;
    logic        rx_valid;
  } pvc_sys_type;

  // Highway master
  typedef struct packed {
    logic [7:0] div;
    logic [4:0] bit_no;
    logic       bclk;
    logic       rx_sync;
    logic       tx_sync;
    logic       rx_data;
    logic [7:0] cur;
    logic [7:0] pend;
    logic       pend_full;
    logic       send_ready;
    logic [1:0] line_meta;
    logic [7:0] rshift;
    logic [7:0] recv;
    logic       recv_valid;
    logic       pwr_o;
    logic       law_o;
    logic       law_oe;
  } pvc_host_type;

  // Sign-magnitude to line code and back; the mapping is its own inverse
  function automatic logic [7:0] pvc_code(input logic [7:0] value,
                                          input logic       a_law);
    pvc_code = a_law ? (value ^ `PVC_A_MASK) : (value ^ `PVC_MU_MASK);
  endfunction
endpackage
